// ### hw/cbts_defines.vh
// Constants for the bit-timing and synchronisation block.
// Assumes a 32-bit APB slave at 125 MHz; included by bare name.
`ifndef CBTS_DEFINES_VH
`define CBTS_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CBTS_ADDR_MODE 12'h000
`define CBTS_ADDR_TIMING 12'h004
`define CBTS_ADDR_STATUS 12'h008
`define CBTS_ADDR_W 12

// ****************************************
// Timing register fields
// ****************************************
`define CBTS_PRESC_LSB 0
`define CBTS_PRESC_MSB 5
`define CBTS_SJW_LSB 6
`define CBTS_SJW_MSB 7
`define CBTS_PROP_LSB 8
`define CBTS_PROP_MSB 10
`define CBTS_PH1_LSB 11
`define CBTS_PH1_MSB 13
`define CBTS_PH2_LSB 14
`define CBTS_PH2_MSB 16
`define CBTS_TRIPLE_BIT 17
`define CBTS_PH2SRC_BIT 18
`define CBTS_TIMING_RESET 19'h0_0000
`define CBTS_TIMING_W 19

// ****************************************
// Fixed quantities
// ****************************************
`define CBTS_IPT_TQ 4'h2
`define CBTS_PH_MAX 4'hF
`define CBTS_IDLE_BITS 4'hB

`endif

// ### hw/cbts_vote.v
// Three-sample majority voter for the received bit.
// Assumes samples arrive already synchronised to clk.
`timescale 1ns/10ps
module cbts_vote (
    input wire clk,
    input wire sys_rst,
    input wire shift,
    input wire level,
    input wire triple,
    output reg vote_q
);
    reg [1:0] hist_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            hist_q <= 2'h3;
        end else if (shift) begin
            hist_q <= {hist_q[0], level};
        end
    end

    // Combinational majority, registered by the caller's timing
    always @* begin
        if (triple) begin
            vote_q = (hist_q[1] & hist_q[0]) | (hist_q[1] & level) |
                     (hist_q[0] & level);
        end else begin
            vote_q = level;
        end
    end
endmodule // cbts_vote

// ### hw/cbts_core.v
// Bit-timing and synchronisation engine with APB register access.
// Assumes bus_receive_pin is asynchronous; 1 is recessive.
`timescale 1ns/10ps
`include "cbts_defines.vh"

// Functional notes
// RULE1: One quantum every 2*(prescaler+1) clocks, prescaler 0..63.
// RULE2: Bit holds 5..25 quanta; software should use at least 8.
// RULE3: Bit opens with a one-quantum sync segment expecting edges.
// RULE4: Propagation segment 1..8 quanta from a 3-bit field.
// RULE5: Phase segment 1 follows, 1..8 quanta.
// RULE6: Received bit decided when phase segment 1 ends.
// RULE7: Phase segment 2 ends bit, 1..8, effective minimum 2 quanta.
// RULE8: Two-quantum processing time after sample point.
// RULE9: Triple sampling takes majority of three half-quantum samples.
// RULE10: Hard sync on falling edge only while idle, restarting bit.
// RULE11: No resync in a bit that had a hard sync.
// RULE12: Jump width 1..4 bounds lengthening and shortening.
// RULE13: Only recessive-to-dominant edges synchronise.
// RULE14: Phase error zero in sync, positive before, negative after.
// RULE15: Error within jump width realigns like hard sync.
// RULE16: Large positive error lengthens phase 1 by jump width.
// RULE17: Large negative error shortens phase 2 by jump width.
// RULE18: At most one synchronisation per bit.
// RULE19: Edge used only if previous sample differs from new level.
// RULE20: No positive-error resync while sending dominant.
// RULE21: Software keeps prop+phase1 >= phase2 >= jump width.
// RULE22: Software should sample near 80 percent of the bit.
// RULE23: Timing writes accepted only in configuration mode.
// RULE24: Source select picks phase2 length or max(phase1, 2).
// RULE25: Triple-sample bit selects majority or single sample.
// RULE26: Jump width from a 2-bit field, multiples of a quantum.
// RULE27: All segment counters advance only on the quantum pulse.
module cbts_core (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire bus_receive_pin,
    input wire tx_dominant,
    output reg sample_strobe,
    output reg rx_bit,
    output reg bit_start,
    output reg hard_sync_pulse,
    output reg resync_pulse
);
    // ****************************************
    // Segment states
    // ****************************************
    localparam ST_SYNC = 2'b00;
    localparam ST_PROP = 2'b01;
    localparam ST_PH1 = 2'b10;
    localparam ST_PH2 = 2'b11;

    reg config_mode_q;
    reg [`CBTS_TIMING_W-1:0] timing_q;
    reg [31:0] prdata_d;
    reg pready_q, pslverr_q;
    reg rx_meta_q, rx_sync_q, rx_prev_q;
    reg [6:0] presc_cnt_q;
    reg tq_q, half_q;
    reg [1:0] seg_q;
    reg [3:0] seg_cnt_q;
    reg [3:0] ph1_len_q, ph2_len_q;
    reg synced_q;
    reg sampled_q;
    reg [3:0] idle_cnt_q;
    reg rx_bit_q, samp_q, start_q, hs_q, rs_q;
    reg bus_val_q;
    wire vote;
    // Declared early: the prescaler restarts on both
    wire hs_go;
    wire rs_realign;

    wire [5:0] presc = timing_q[`CBTS_PRESC_MSB:`CBTS_PRESC_LSB];
    wire [3:0] sync_jump_width = {2'h0, timing_q[`CBTS_SJW_MSB:`CBTS_SJW_LSB]}
        + 4'h1; // [RULE26] [RULE12]
    wire [3:0] prop_len = {1'b0, timing_q[`CBTS_PROP_MSB:`CBTS_PROP_LSB]}
        + 4'h1; // [RULE4]
    wire [3:0] ph1_cfg = {1'b0, timing_q[`CBTS_PH1_MSB:`CBTS_PH1_LSB]}
        + 4'h1; // [RULE5]
    wire [3:0] ph2_prog = {1'b0, timing_q[`CBTS_PH2_MSB:`CBTS_PH2_LSB]}
        + 4'h1;
    wire triple = timing_q[`CBTS_TRIPLE_BIT];
    wire ph2_src = timing_q[`CBTS_PH2SRC_BIT];

    function [3:0] max4;
        input [3:0] a;
        input [3:0] b;
        begin
            max4 = (a > b) ? a : b;
        end
    endfunction

    // Configured phase 2 never shorter than processing time
    wire [3:0] ph2_cfg = ph2_src ? max4(ph2_prog, `CBTS_IPT_TQ)
        : max4(ph1_cfg, `CBTS_IPT_TQ); // [RULE24] [RULE7] [RULE8]

    // ****************************************
    // APB slave
    // ****************************************
    // Write lands on the completing edge, where pready is sampled
    wire wr = psel & penable & pwrite & pready_q;
    wire rd_setup = psel & ~penable;

    always @(posedge clk) begin
        if (sys_rst) begin
            config_mode_q <= 1'b1;
            timing_q <= `CBTS_TIMING_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= 1'b0;
            if (rd_setup) begin
                prdata <= prdata_d;
            end
            if (psel & penable & ~pready_q) begin
                if (paddr != `CBTS_ADDR_MODE &&
                    paddr != `CBTS_ADDR_TIMING &&
                    paddr != `CBTS_ADDR_STATUS) begin
                    pslverr_q <= 1'b1;
                end
            end
            if (wr && paddr == `CBTS_ADDR_MODE) begin
                config_mode_q <= pwdata[0];
            end else if (wr && paddr == `CBTS_ADDR_TIMING &&
                         config_mode_q) begin
                timing_q <= pwdata[`CBTS_TIMING_W-1:0]; // [RULE23]
            end
        end
    end

    always @* begin
        if (paddr == `CBTS_ADDR_MODE) begin
            prdata_d = {31'h0000_0000, config_mode_q};
        end else if (paddr == `CBTS_ADDR_TIMING) begin
            prdata_d = {13'h0000, timing_q};
        end else if (paddr == `CBTS_ADDR_STATUS) begin
            prdata_d = {24'h00_0000, synced_q, rx_bit_q, bus_val_q,
                        seg_q, 3'h0};
        end else begin
            prdata_d = 32'h0000_0000;
        end
    end

    always @* begin
        pready = pready_q;
        pslverr = pslverr_q;
    end

    // ****************************************
    // Pin synchroniser and quantum prescaler
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= bus_receive_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // Falling edge only; rising edges carry no timing
    wire fall = rx_prev_q & ~rx_sync_q; // [RULE13]
    // Edge must change the last sampled level
    wire edge_ok = fall & bus_val_q; // [RULE19]

    wire [6:0] presc_top = {presc, 1'b1};
    wire [6:0] presc_half = {1'b0, presc};
    // Restart the quantum so a sync edge falls in the sync segment
    always @(posedge clk) begin
        if (sys_rst || hs_go || rs_realign) begin
            presc_cnt_q <= 7'h00;
            tq_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            // Period 2*(P+1) clocks
            if (presc_cnt_q == presc_top) begin
                presc_cnt_q <= 7'h00;
                tq_q <= 1'b1; // [RULE1] [RULE27]
            end else begin
                presc_cnt_q <= presc_cnt_q + 7'h01;
                tq_q <= 1'b0;
            end
            half_q <= (presc_cnt_q == presc_half);
        end
    end

    cbts_vote u_vote (
        .clk(clk),
        .sys_rst(sys_rst),
        .shift(half_q | tq_q),
        .level(rx_sync_q),
        .triple(triple),
        .vote_q(vote)
    ); // [RULE9] [RULE25]

    // ****************************************
    // Synchronisation decisions
    // ****************************************
    // Idle once enough recessive bits in a row were sampled
    wire idle = (idle_cnt_q == `CBTS_IDLE_BITS);
    // Hard sync only on start of frame
    assign hs_go = edge_ok & idle & ~synced_q; // [RULE10]
    wire in_sync = (seg_q == ST_SYNC);
    wire pos_err = (seg_q == ST_PROP) | (seg_q == ST_PH1);
    wire neg_err = (seg_q == ST_PH2);
    // Elapsed quanta since bit start, before the sample point
    wire [4:0] pos_mag = (seg_q == ST_PROP) ? {1'b0, seg_cnt_q} + 5'h1
        : {1'b0, prop_len} + {1'b0, seg_cnt_q} + 5'h1; // [RULE14]
    // Quanta still left in phase 2 when the edge arrives
    wire [3:0] neg_mag = ph2_len_q - seg_cnt_q;
    // One sync per bit; no positive resync while sending dominant
    wire rs_ok = edge_ok & ~idle & ~synced_q & ~in_sync &
        ~(pos_err & tx_dominant); // [RULE18] [RULE11] [RULE20]
    wire rs_small = rs_ok & ((pos_err & (pos_mag <= {1'b0, sync_jump_width})) |
        (neg_err & (neg_mag <= sync_jump_width))); // [RULE15]
    assign rs_realign = rs_small;
    wire rs_long = rs_ok & pos_err & ~rs_small; // [RULE16]
    wire rs_short = rs_ok & neg_err & ~rs_small; // [RULE17]

    // ****************************************
    // Segment sequencer
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            seg_q <= ST_SYNC;
            seg_cnt_q <= 4'h0;
            ph1_len_q <= 4'h1;
            ph2_len_q <= `CBTS_IPT_TQ;
            synced_q <= 1'b0;
            sampled_q <= 1'b0;
            bus_val_q <= 1'b1;
            idle_cnt_q <= 4'h0;
            rx_bit_q <= 1'b1;
            samp_q <= 1'b0;
            start_q <= 1'b0;
            hs_q <= 1'b0;
            rs_q <= 1'b0;
        end else begin
            samp_q <= 1'b0;
            start_q <= 1'b0;
            hs_q <= hs_go;
            rs_q <= rs_ok;
            if (hs_go || rs_realign) begin
                // Restart in sync segment so edge lies within it
                seg_q <= ST_SYNC;
                seg_cnt_q <= 4'h0;
                synced_q <= 1'b1;
                ph1_len_q <= ph1_cfg;
                ph2_len_q <= ph2_cfg;
                if (hs_go) begin
                    idle_cnt_q <= 4'h0;
                end
                start_q <= 1'b1; // [RULE10] [RULE15]
            end else begin
                if (rs_long) begin
                    ph1_len_q <= ph1_len_q + sync_jump_width; // [RULE16]
                    synced_q <= 1'b1;
                end
                if (rs_short) begin
                    ph2_len_q <= ph2_len_q - sync_jump_width; // [RULE17]
                    synced_q <= 1'b1;
                end
                if (tq_q) begin
                    case (seg_q)
                        ST_SYNC: begin
                            // Sync segment is one quantum
                            seg_q <= ST_PROP; // [RULE3]
                            seg_cnt_q <= 4'h0;
                        end
                        ST_PROP: begin
                            if (seg_cnt_q == prop_len - 4'h1) begin
                                seg_q <= ST_PH1;
                                seg_cnt_q <= 4'h0;
                            end else begin
                                seg_cnt_q <= seg_cnt_q + 4'h1;
                            end
                        end
                        ST_PH1: begin
                            if (seg_cnt_q == ph1_len_q - 4'h1) begin
                                seg_q <= ST_PH2;
                                seg_cnt_q <= 4'h0;
                                rx_bit_q <= vote; // [RULE6] [RULE9]
                                bus_val_q <= vote;
                                samp_q <= 1'b1;
                                sampled_q <= 1'b1;
                                if (vote && !idle) begin
                                    idle_cnt_q <= idle_cnt_q + 4'h1;
                                end else if (!vote) begin
                                    idle_cnt_q <= 4'h0;
                                end
                            end else begin
                                seg_cnt_q <= seg_cnt_q + 4'h1;
                            end
                        end
                        default: begin
                            // Shortened phase 2 may already be done
                            if (seg_cnt_q + 4'h1 >= ph2_len_q) begin
                                seg_q <= ST_SYNC;
                                seg_cnt_q <= 4'h0;
                                synced_q <= 1'b0; // [RULE18]
                                ph1_len_q <= ph1_cfg;
                                ph2_len_q <= ph2_cfg; // [RULE8]
                                start_q <= 1'b1;
                            end else begin
                                seg_cnt_q <= seg_cnt_q + 4'h1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    // Minimum 5 quanta bit arises from 1+1+1+2 [RULE2]
    always @(posedge clk) begin
        if (sys_rst) begin
            sample_strobe <= 1'b0;
            rx_bit <= 1'b1;
            bit_start <= 1'b0;
            hard_sync_pulse <= 1'b0;
            resync_pulse <= 1'b0;
        end else begin
            sample_strobe <= samp_q;
            rx_bit <= rx_bit_q;
            bit_start <= start_q;
            hard_sync_pulse <= hs_q;
            resync_pulse <= rs_q;
        end
    end
endmodule // cbts_core

// ### tb/cbts_core_props.sv
// Checker for the APB side and bit-timing pulses of cbts_core.
// Assumes it is bound to cbts_core and sees only its ports.
`timescale 1ns/10ps
module cbts_core_props (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sample_strobe,
    input wire rx_bit,
    input wire bit_start,
    input wire hard_sync_pulse,
    input wire resync_pulse
);
    // ********************
    // Helper and properties
    // ********************
    logic seen_q;
    logic seen_d;
    // Hard sync may restart the bit, so the new bit inherits its sync
    assign seen_d = bit_start ? (hard_sync_pulse | resync_pulse)
        : (seen_q | hard_sync_pulse | resync_pulse);
    always @(posedge clk) begin
        if (sys_rst) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("no pready one cycle after access");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_HOLD: assert property ($changed(prdata) |-> $past(psel))
        else $error("read data changed outside a transfer");
    AST_ONE_SYNC: assert property (
        (hard_sync_pulse || resync_pulse) && !bit_start |-> !seen_q)
        else $error("second synchronisation in one bit");
    AST_STROBE_GAP: assert property (
        sample_strobe |=> !sample_strobe [*5])
        else $error("sample points too close");
    AST_START_GAP: assert property (
        bit_start |=> !sample_strobe [*5])
        else $error("sample too soon after bit start");
    AST_RX_ON_STROBE: assert property (
        $changed(rx_bit) |-> sample_strobe || $past(sample_strobe))
        else $error("received bit changed off the sample point");
    AST_HARD_SYNC_IDLE: assert property (
        hard_sync_pulse |-> rx_bit)
        else $error("hard sync while last bit dominant");
endmodule // cbts_core_props

bind cbts_core cbts_core_props u_props (.clk, .sys_rst, .psel, .penable,
    .prdata, .pready, .pslverr, .sample_strobe, .rx_bit, .bit_start,
    .hard_sync_pulse, .resync_pulse);

// ### tb/cbts_bus_node.sv
// Behavioural remote node driving the receive line of the bus.
// Assumes a pull-up: the released bus reads recessive (1).
`timescale 1ns/10ps
module cbts_bus_node (
    input wire clk,
    output logic line
);
    initial line = 1'b1;
    // Bits go out first bit first, each per clocks long
    task automatic send(input logic [15:0] bits, input int n,
                        input int per);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            line <= bits[i];
            repeat (per - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
    endtask
endmodule // cbts_bus_node

// ### tb/tb_cbts_core.sv
// Self-checking bench for cbts_core: registers, bit timing, sync.
// Assumes cbts_bus_node drives the receive pin.
`timescale 1ns/10ps
`include "cbts_defines.vh"
module tb_cbts_core;
    logic clk, sys_rst, psel, penable, pwrite, tx_dominant, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, bus_receive_pin, sample_strobe, rx_bit;
    logic bit_start, hard_sync_pulse, resync_pulse, strobe_d;
    logic [15:0] rxs;
    int n_mismatch, n_compared, n_hs, n_rs, cap, b, s, p, r, f, g, c;
    int ex;

    cbts_core u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .bus_receive_pin,
        .tx_dominant, .sample_strobe, .rx_bit, .bit_start,
        .hard_sync_pulse, .resync_pulse);
    cbts_bus_node u_node (.clk(clk), .line(bus_receive_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ********************
    // Checking and bus tasks
    // ********************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    function int ph2e(int p1, int p2, int src);
        return src ? (p2 > 2 ? p2 : 2) : (p1 > 2 ? p1 : 2);
    endfunction

    function logic [31:0] cfg(int q, int j, int pr, int p1, int p2,
                              int t, int src);
        return 32'(q | (j - 1) << 6 | (pr - 1) << 8 | (p1 - 1) << 11
            | (p2 - 1) << 14 | t << 17 | src << 18);
    endfunction

    // Timing changes only in config mode, so step in and out
    task setcfg(input logic [31:0] v);
        apb(1'b1, `CBTS_ADDR_MODE, 32'h0000_0001);
        apb(1'b1, `CBTS_ADDR_TIMING, v);
        apb(1'b1, `CBTS_ADDR_MODE, 32'h0000_0000);
    endtask

    // Idle bus: no edges, so the bit runs at its nominal length
    task meas(int q, int pr, int p1, int p2, int src);
        setcfg(cfg(q, 1, pr, p1, p2, 0, src));
        repeat (2) begin
            @(posedge clk);
            while (bit_start !== 1'b1) @(posedge clk);
        end
        b = 0;
        s = 0;
        do begin
            @(posedge clk);
            b++;
            if (sample_strobe === 1'b1) s = b;
        end while (bit_start !== 1'b1 && b < 4000);
        ex = 2 * (q + 1) * (1 + pr + p1 + ph2e(p1, p2, src));
        check(b, ex);
        check(s, 2 * (q + 1) * (1 + pr + p1));
    endtask

    // Nominal bit is 52 clocks; 50 needs resync to decode
    task frame(int per, logic txd, int t);
        setcfg(cfg(1, 2, 2, 5, 1, t, 0));
        tx_dominant <= txd;
        repeat (700) @(posedge clk);
        n_hs = 0;
        n_rs = 0;
        u_node.send(16'h3319, 16, per);
        repeat (200) @(posedge clk);
        tx_dominant <= 1'b0;
        check(rxs, 16'h3319);
        check(n_hs, 1);
        if (per != 52) check(n_rs > 0, !txd);
    endtask

    always @(posedge clk) begin
        strobe_d <= sample_strobe;
        if (hard_sync_pulse === 1'b1) begin
            n_hs++;
            cap = 0;
        end
        if (resync_pulse === 1'b1) n_rs++;
        if (strobe_d === 1'b1 && cap < 16) begin
            rxs = {rxs[14:0], rx_bit};
            cap++;
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done;
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        {sys_rst, psel, penable, pwrite, tx_dominant, strobe_d} = 6'h01 << 5;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rxs = 16'h0000;
        cap = 16;
        void'($urandom(32'h0000_d364));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `CBTS_ADDR_MODE, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        check(err, 1'b0);
        apb(1'b0, `CBTS_ADDR_TIMING, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        check(err, 1'b1);
        apb(1'b1, `CBTS_ADDR_TIMING, 32'h0007_ffff);
        apb(1'b0, `CBTS_ADDR_TIMING, 32'h0000_0000);
        check(rd, 32'h0007_ffff);
        apb(1'b1, `CBTS_ADDR_MODE, 32'h0000_0000);
        apb(1'b1, `CBTS_ADDR_TIMING, 32'h0000_1234);
        apb(1'b0, `CBTS_ADDR_TIMING, 32'h0000_0000);
        check(rd, 32'h0007_ffff);
        meas(63, 8, 8, 8, 1);
        meas(0, 1, 3, 3, 1);
        meas(2, 2, 3, 1, 1);
        meas(1, 8, 3, 3, 1);
        repeat (6) begin
            do begin
                p = $urandom % 4;
                r = 1 + $urandom % 8;
                f = 1 + $urandom % 8;
                g = 1 + $urandom % 8;
                c = $urandom % 2;
            end while (r + f < ph2e(f, g, c) ||
                       1 + r + f + ph2e(f, g, c) < 8);
            meas(p, r, f, g, c);
        end
        frame(50, 1'b0, 0);
        frame(54, 1'b1, 1);
        frame(52, 1'b0, 1);
        test_done;
    end
endmodule // tb_cbts_core
